// ==== core/adchps_defines.svh ====
// field positions, reset value and timing counts of the converter host port
`ifndef ADCHPS_DEFINES_SVH
`define ADCHPS_DEFINES_SVH
`define ADCHPS_CFG_RESET      8'h10
`define ADCHPS_CMD_MSB        7
`define ADCHPS_CMD_LSB        5
`define ADCHPS_SYNC_BIT       4
`define ADCHPS_BW_BIT         3
`define ADCHPS_SE_BIT         2
`define ADCHPS_ACQ_MSB        1
`define ADCHPS_ACQ_LSB        0
`define ADCHPS_ACQ_CLKS_0     7'd9
`define ADCHPS_ACQ_CLKS_1     7'd15
`define ADCHPS_ACQ_CLKS_2     7'd47
`define ADCHPS_ACQ_CLKS_3     7'd79
`define ADCHPS_CAL_REPEATS    4'd8
`define ADCHPS_CAP_COUNT      4'd12
`define ADCHPS_CONV_CLKS      8'd44
`define ADCHPS_MEAS_CLKS      8'd16
`endif

// ==== core/adchps_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module adchps_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  // elaboration check: pointers wrap by overflow, so only powers of two work
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo width or depth cannot be served");
  end
  typedef struct packed {
    logic [AW-1:0] wp;   // write pointer
    logic [AW-1:0] rp;   // read pointer
    logic [AW:0]   cnt;  // fill level
  } adchps_fifo_type;
  adchps_fifo_type s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];  // storage words
  logic push, pop;
  // handshakes on each side
  always_comb begin
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    s_d  = s_q;
    if (push) s_d.wp = s_q.wp + 1'b1;
    if (pop)  s_d.rp = s_q.rp + 1'b1;
    s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  // pointer state and storage
  always_ff @(posedge clk) begin
    if (rst) s_q <= '0;
    else s_q <= s_d;
    if (push) mem[s_q.wp] <= in_data;
  end
  assign in_ready  = (s_q.cnt != DEPTH[AW:0]);  // honest full
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = mem[s_q.rp];
endmodule : adchps_fifo

// ==== core/adchps_pkg.sv ====
// types shared by the converter host port files
package adchps_pkg;
  typedef enum logic [2:0] {
    ADCHPS_CMD_STANDBY = 3'h0,
    ADCHPS_CMD_FULLCAL = 3'h1,
    ADCHPS_CMD_AUTOZ   = 3'h2,
    ADCHPS_CMD_RESET   = 3'h3,
    ADCHPS_CMD_START   = 3'h4
  } adchps_cmd_type;
  // gray-coded along standby, idle, acquire, convert
  typedef enum logic [2:0] {
    ADCHPS_ST_STANDBY = 3'b000,
    ADCHPS_ST_IDLE    = 3'b001,
    ADCHPS_ST_ACQ     = 3'b011,
    ADCHPS_ST_CONV    = 3'b010,
    ADCHPS_ST_CAL     = 3'b110
  } adchps_state_type;
endpackage : adchps_pkg

// ==== core/adchps_top.sv ====
// converter host port: configuration write, result read, sequencing and ready
`timescale 1ns/1ps
`include "adchps_defines.svh"
module adchps_top (
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic        CS_N,             // chip select
  input  wire logic        RD_N,             // read strobe
  input  wire logic        WR_N,             // write strobe
  input  wire logic        WRITE_EDGE_SELECT,// high: latch on strobe fall
  input  wire logic [12:0] PARALLEL_DATA_I,  // data pins as seen
  output logic      [12:0] PARALLEL_DATA_O,  // data pins driven
  output logic      [12:0] PARALLEL_DATA_OE, // per-pin drive enable
  input  wire logic        SYNC_I,           // sync pin as seen
  output logic             SYNC_O,           // sync pin driven
  output logic             SYNC_OE,          // sync pin drive enable
  output logic             READY_N,          // ready, active low
  input  wire logic [12:0] RAW_SAMPLE,       // raw code from the analog core
  input  wire logic [12:0] RAW_OFFSET,       // measured offset from the analog core
  output logic             SAMPLE_HOLD,      // high while holding for conversion
  output logic             RESULT_VALID,     // result stream beat
  output logic      [12:0] RESULT_DATA,      // corrected result stream
  input  wire logic        RESULT_READY      // stream sink ready
);
  // pin synchronisers: three stages, change accepted when stages two and three agree
  logic [2:0] rd_sy, wr_sy, cs_sy, sy_sy, we_sy;
  always_ff @(posedge REF_CLK) begin
    rd_sy <= {rd_sy[1:0], RD_N};
    wr_sy <= {wr_sy[1:0], WR_N};
    cs_sy <= {cs_sy[1:0], CS_N};
    sy_sy <= {sy_sy[1:0], SYNC_I};
    we_sy <= {we_sy[1:0], WRITE_EDGE_SELECT};
  end
  // data pins need no filter: they are only sampled once the strobes have settled
  logic [12:0] din_q;
  always_ff @(posedge REF_CLK) din_q <= PARALLEL_DATA_I;

  // full machine state in one record
  typedef struct packed {
    logic [7:0]                 cfg;      // configuration register
    adchps_pkg::adchps_state_type st;     // sequencer state
    logic                       rd_f;     // filtered read strobe (low active)
    logic                       wr_f;     // filtered write strobe
    logic                       cs_f;     // filtered chip select
    logic                       sy_f;     // filtered sync pin
    logic                       we_f;     // filtered edge select
    logic                       hi_byte;  // next eight-bit read gives upper byte
    logic [6:0]                 acq_cnt;  // acquisition clock count
    logic [7:0]                 phase;    // clocks in convert or measurement step
    logic [3:0]                 rep;      // measurement repetitions done
    logic [3:0]                 cap;      // capacitor under test
    logic                       full_cal; // calibration is the full kind
    logic [16:0]                off_acc;  // offset sum
    logic [12:0]                off_coef; // stored offset coefficient
    logic [12:0]                lin_coef; // stored linearity trim
    logic [12:0]                result;   // data register
    logic                       push;     // new result for stream
    logic                       rdy_n;    // ready output
    logic                       sync_o;   // sync output
    logic [12:0]                dout;     // data pins value
    logic [12:0]                doe;      // data pins enable
    logic                       rdy_pin;  // ready pin as driven
    logic                       sync_oe;  // sync pin drive enable
    logic                       hold;     // sample held for conversion
  } adchps_state_rec_type;
  adchps_state_rec_type s_q, s_d;

  logic rd_rise, rd_fall, wr_rise, wr_fall, sy_rise, wr_take, acq_done;
  logic [6:0] acq_len;
  logic [13:0] corr;
  logic fifo_in_ready;
  adchps_pkg::adchps_cmd_type new_cmd;

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.push = 1'b0;
    // filtered levels change only when the last two stages agree
    if (rd_sy[1] == rd_sy[2]) s_d.rd_f = rd_sy[2];
    if (wr_sy[1] == wr_sy[2]) s_d.wr_f = wr_sy[2];
    if (cs_sy[1] == cs_sy[2]) s_d.cs_f = cs_sy[2];
    if (sy_sy[1] == sy_sy[2]) s_d.sy_f = sy_sy[2];
    if (we_sy[1] == we_sy[2]) s_d.we_f = we_sy[2];
    rd_rise = !s_q.rd_f && s_d.rd_f && !s_q.cs_f;
    rd_fall = s_q.rd_f && !s_d.rd_f && !s_q.cs_f;
    wr_rise = !s_q.wr_f && s_d.wr_f && !s_q.cs_f;
    wr_fall = s_q.wr_f && !s_d.wr_f && !s_q.cs_f;
    sy_rise = !s_q.sy_f && s_d.sy_f;
    // latch edge picked by the edge select level
    wr_take = s_q.we_f ? wr_fall : wr_rise;
    new_cmd = adchps_pkg::adchps_cmd_type'(din_q[`ADCHPS_CMD_MSB:`ADCHPS_CMD_LSB]);
    // acquisition length lookup
    case (s_q.cfg[`ADCHPS_ACQ_MSB:`ADCHPS_ACQ_LSB])
      2'b00:   acq_len = `ADCHPS_ACQ_CLKS_0;
      2'b01:   acq_len = `ADCHPS_ACQ_CLKS_1;
      2'b10:   acq_len = `ADCHPS_ACQ_CLKS_2;
      default: acq_len = `ADCHPS_ACQ_CLKS_3;
    endcase
    acq_done = (s_q.acq_cnt == acq_len - 7'd1);
    // correction arithmetic applied to every result
    corr = {RAW_SAMPLE[12], RAW_SAMPLE} - {s_q.off_coef[12], s_q.off_coef}
           + {s_q.lin_coef[12], s_q.lin_coef};
    // read side: drive pins while reading, byte order in eight-bit mode
    if (rd_fall) begin
      if (s_q.cfg[`ADCHPS_BW_BIT]) begin
        s_d.dout = s_q.result;
        s_d.doe  = 13'h1fff;
      end else begin
        // upper byte sign extended in narrow mode
        s_d.dout = s_q.hi_byte ? {5'h00, {3{s_q.result[12]}}, s_q.result[12:8]}
                               : {5'h00, s_q.result[7:0]};
        s_d.doe  = 13'h00ff;
      end
    end else if (rd_rise || s_q.rd_f) begin
      s_d.doe = 13'h0000;
    end
    // sequencer
    case (s_q.st)
      adchps_pkg::ADCHPS_ST_STANDBY: begin
        s_d.rdy_n = 1'b1;
      end
      adchps_pkg::ADCHPS_ST_IDLE: begin
        // a read that finishes a result fetch starts the next sample
        if (rd_rise && s_q.cfg[`ADCHPS_CMD_MSB:`ADCHPS_CMD_LSB] == adchps_pkg::ADCHPS_CMD_START
            && (s_q.cfg[`ADCHPS_BW_BIT] || s_q.hi_byte)) begin
          s_d.rdy_n   = 1'b1;
          s_d.acq_cnt = 7'd0;
          s_d.st      = adchps_pkg::ADCHPS_ST_ACQ;
        end else if (sy_rise && s_q.cfg[`ADCHPS_SYNC_BIT]
                     && s_q.cfg[`ADCHPS_CMD_MSB:`ADCHPS_CMD_LSB] == adchps_pkg::ADCHPS_CMD_START) begin
          s_d.rdy_n = 1'b1;
          s_d.phase = 8'd0;
          s_d.st    = adchps_pkg::ADCHPS_ST_CONV;
        end
      end
      adchps_pkg::ADCHPS_ST_ACQ: begin
        if (s_q.cfg[`ADCHPS_SYNC_BIT]) begin
          // length select ignored; sync edge ends the window
          if (sy_rise) begin
            s_d.phase = 8'd0;
            s_d.st    = adchps_pkg::ADCHPS_ST_CONV;
          end
        end else if (acq_done) begin
          s_d.phase  = 8'd0;
          s_d.sync_o = 1'b1;
          s_d.st     = adchps_pkg::ADCHPS_ST_CONV;
        end else begin
          s_d.acq_cnt = s_q.acq_cnt + 7'd1;
        end
      end
      adchps_pkg::ADCHPS_ST_CONV: begin
        s_d.sync_o = !s_q.cfg[`ADCHPS_SYNC_BIT];
        if (s_q.phase == `ADCHPS_CONV_CLKS - 8'd1) begin
          // clamp negatives when single-ended is chosen
          s_d.result = (s_q.cfg[`ADCHPS_SE_BIT] && corr[13]) ? 13'h0000 : corr[12:0];
          s_d.push   = 1'b1;
          s_d.rdy_n  = 1'b0;
          s_d.sync_o = 1'b0;
          s_d.st     = adchps_pkg::ADCHPS_ST_IDLE;
        end else begin
          s_d.phase = s_q.phase + 8'd1;
        end
      end
      adchps_pkg::ADCHPS_ST_CAL: begin
        if (s_q.phase == `ADCHPS_MEAS_CLKS - 8'd1) begin
          s_d.phase = 8'd0;
          if (s_q.cap == 4'd0) begin
            s_d.off_acc = s_q.off_acc + {{4{RAW_OFFSET[12]}}, RAW_OFFSET};
          end
          if (!s_q.full_cal) begin
            s_d.off_coef = RAW_OFFSET;
            s_d.rdy_n    = 1'b0;
            s_d.st       = adchps_pkg::ADCHPS_ST_IDLE;
          end else if (s_q.rep != `ADCHPS_CAL_REPEATS - 4'd1) begin
            s_d.rep = s_q.rep + 4'd1;
          end else if (s_q.cap == 4'd0) begin
            // average of eight offset samples
            s_d.off_coef = s_d.off_acc[15:3];
            s_d.rep = 4'd0;
            s_d.cap = 4'd1;
          end else if (s_q.cap != `ADCHPS_CAP_COUNT) begin
            // capacitor mismatch folded into the trim, eight compares each
            s_d.lin_coef = s_q.lin_coef + {{3{RAW_OFFSET[12]}}, RAW_OFFSET[12:3]};
            s_d.rep = 4'd0;
            s_d.cap = s_q.cap + 4'd1;
          end else begin
            s_d.rdy_n = 1'b0;
            s_d.st    = adchps_pkg::ADCHPS_ST_IDLE;
          end
        end else begin
          s_d.phase = s_q.phase + 8'd1;
        end
      end
      default: s_d.st = adchps_pkg::ADCHPS_ST_STANDBY;
    endcase
    // result fetch pointer: completes on the second narrow read
    if (rd_rise) s_d.hi_byte = !s_q.cfg[`ADCHPS_BW_BIT] && !s_q.hi_byte;
    // a configuration write overrides the sequencer
    if (wr_take) begin
      // narrow and wide modes both take the whole byte in one cycle
      s_d.cfg = din_q[7:0];
      s_d.hi_byte = 1'b0;
      s_d.sync_o = 1'b0;
      case (new_cmd)
        adchps_pkg::ADCHPS_CMD_STANDBY: begin
          s_d.st    = adchps_pkg::ADCHPS_ST_STANDBY;
          s_d.rdy_n = 1'b1;
        end
        adchps_pkg::ADCHPS_CMD_FULLCAL, adchps_pkg::ADCHPS_CMD_AUTOZ: begin
          s_d.st       = adchps_pkg::ADCHPS_ST_CAL;
          s_d.rdy_n    = 1'b1;
          s_d.full_cal = (new_cmd == adchps_pkg::ADCHPS_CMD_FULLCAL);
          s_d.phase    = 8'd0;
          s_d.rep      = 4'd0;
          s_d.cap      = 4'd0;
          s_d.off_acc  = 17'h00000;
          if (new_cmd == adchps_pkg::ADCHPS_CMD_FULLCAL) s_d.lin_coef = 13'h0000;
        end
        default: begin
          // reset and start both land ready; reset aborts anything running
          s_d.st    = adchps_pkg::ADCHPS_ST_IDLE;
          s_d.rdy_n = 1'b0;
        end
      endcase
    end
    // pin-facing copies so every pin-side output leaves a flip-flop; a push in flight keeps
    // ready high until the buffer's room is known, so a full buffer never flashes ready
    s_d.rdy_pin = s_d.rdy_n || !fifo_in_ready || s_d.push || s_q.push;
    s_d.sync_oe = !s_d.cfg[`ADCHPS_SYNC_BIT];
    s_d.hold    = (s_d.st == adchps_pkg::ADCHPS_ST_CONV);
  end

  // state register; power-up gives standby, narrow bus, sync mode
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      s_q       <= '0;
      s_q.cfg   <= `ADCHPS_CFG_RESET;
      s_q.st    <= adchps_pkg::ADCHPS_ST_STANDBY;
      s_q.rd_f  <= 1'b1;
      s_q.wr_f  <= 1'b1;
      s_q.cs_f  <= 1'b1;
      s_q.rdy_n <= 1'b1;
      s_q.rdy_pin <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // corrected results stream out through a buffer; a result pushed into a full buffer is lost,
  // since the sequencer never stalls on the buffer and only READY_N is held high
  adchps_fifo #(.WIDTH(13), .DEPTH(16)) u_fifo (
    .clk       (REF_CLK),
    .rst       (RESET),
    .in_data   (s_q.result),
    .in_valid  (s_q.push),
    .in_ready  (fifo_in_ready),
    .out_data  (RESULT_DATA),
    .out_valid (RESULT_VALID),
    .out_ready (RESULT_READY)
  );

  // outputs straight from the state record
  assign PARALLEL_DATA_O  = s_q.dout;
  assign PARALLEL_DATA_OE = s_q.doe;
  assign SYNC_O           = s_q.sync_o;
  assign SYNC_OE          = s_q.sync_oe;
  assign READY_N          = s_q.rdy_pin;
  assign SAMPLE_HOLD      = s_q.hold;

  // guards on pins, ready and the sequencer
  AST_NARROW_PINS: assert property (@(posedge REF_CLK) disable iff (RESET)
    !s_q.cfg[`ADCHPS_BW_BIT] |-> PARALLEL_DATA_OE[12:8] == 5'h00)
    else $error("upper pins driven in narrow mode");
  AST_STANDBY_READY: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_q.st == adchps_pkg::ADCHPS_ST_STANDBY |-> READY_N)
    else $error("ready low in standby");
  AST_LEAVE_STANDBY: assert property (@(posedge REF_CLK) disable iff (RESET)
    wr_take && (new_cmd == adchps_pkg::ADCHPS_CMD_RESET || new_cmd == adchps_pkg::ADCHPS_CMD_START)
    |=> !s_q.rdy_n && s_q.st == adchps_pkg::ADCHPS_ST_IDLE)
    else $error("non-standby command did not make ready");
  AST_SYNC_DIR: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_q.cfg[`ADCHPS_SYNC_BIT] |-> !SYNC_OE)
    else $error("sync pin driven in sync mode");
  AST_ACQ_LEN: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_q.st == adchps_pkg::ADCHPS_ST_ACQ && !s_q.cfg[`ADCHPS_SYNC_BIT] && !wr_take
    |-> s_q.acq_cnt < acq_len)
    else $error("acquisition count overran");
  AST_ACQ_END: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_q.st == adchps_pkg::ADCHPS_ST_ACQ && !s_q.cfg[`ADCHPS_SYNC_BIT] && acq_done && !wr_take
    |=> s_q.sync_o && s_q.st == adchps_pkg::ADCHPS_ST_CONV)
    else $error("sync output did not rise after acquisition");
  AST_CAL_BUSY: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_q.st == adchps_pkg::ADCHPS_ST_CAL |-> s_q.rdy_n)
    else $error("ready low during calibration");
  AST_CFG_LOAD: assert property (@(posedge REF_CLK) disable iff (RESET)
    wr_take |=> s_q.cfg == $past(din_q[7:0]))
    else $error("configuration not loaded in one write");
  AST_NARROW_READ: assert property (@(posedge REF_CLK) disable iff (RESET)
    rd_fall && !s_q.cfg[`ADCHPS_BW_BIT] |=> PARALLEL_DATA_OE == 13'h00ff)
    else $error("narrow read did not drive the low byte pins");
  AST_WIDE_READ: assert property (@(posedge REF_CLK) disable iff (RESET)
    rd_fall && s_q.cfg[`ADCHPS_BW_BIT] |=> PARALLEL_DATA_OE == 13'h1fff && PARALLEL_DATA_O == $past(s_q.result))
    else $error("wide read did not show the whole result");
  AST_ACQ_START: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_q.st == adchps_pkg::ADCHPS_ST_IDLE && rd_rise && !wr_take && !s_q.cfg[`ADCHPS_SYNC_BIT]
    && s_q.cfg[`ADCHPS_CMD_MSB:`ADCHPS_CMD_LSB] == adchps_pkg::ADCHPS_CMD_START
    && (s_q.cfg[`ADCHPS_BW_BIT] || s_q.hi_byte)
    |=> s_q.st == adchps_pkg::ADCHPS_ST_ACQ && s_q.acq_cnt == 7'd0 && READY_N)
    else $error("finishing read did not start acquisition");
  AST_AZ_STORE: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_q.st == adchps_pkg::ADCHPS_ST_CAL && !s_q.full_cal && !wr_take
    && s_q.phase == `ADCHPS_MEAS_CLKS - 8'd1
    |=> s_q.off_coef == $past(RAW_OFFSET) && !s_q.rdy_n)
    else $error("auto-zero did not store its single measurement");
  AST_READY_BUSY: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_q.st == adchps_pkg::ADCHPS_ST_ACQ || s_q.st == adchps_pkg::ADCHPS_ST_CONV |-> READY_N)
    else $error("ready low while sampling or converting");
  AST_FULL_READY: assert property (@(posedge REF_CLK) disable iff (RESET)
    !fifo_in_ready |=> READY_N)
    else $error("ready low with the result buffer full");
endmodule : adchps_top

// ==== dv/adc_host_port_and_sequencer_tb_top.sv ====
// self-checking bench for the converter host port
`timescale 1ns/1ps
`include "adchps_defines.svh"
module adc_host_port_and_sequencer_tb_top;
  logic        ref_clk;            // 100 MHz
  logic        rst;                // sync reset, active high
  logic        wes;                // write edge select
  logic        sync_i;             // sync pin stimulus
  logic        rr;                 // stream sink ready
  logic [12:0] raw;                // analog core code
  logic [12:0] off;                // analog core offset measurement
  wire  logic  cs_n, rd_n, wr_n;   // host strobes
  wire  logic [12:0] pins, d_o, d_oe, rdata;
  wire  logic  sync_o, sync_oe, ready_n, hold, rv;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0, t_rise = 0, t_sync = 0, hi_cnt = 0, beats = 0;
  int          acq [4];
  int          base, az, fc;
  logic        rdy_p, syn_p;       // previous ready and sync output
  logic [12:0] last_res, d1, d2, oe, prev;
  localparam int LIMIT = 60000;    // run ceiling, tests need under a tenth
  localparam logic [12:0] RAWS [4] = '{13'h0abc, 13'h1f05, 13'h0123, 13'h1800};
  localparam int CLKS [4] = '{`ADCHPS_ACQ_CLKS_0, `ADCHPS_ACQ_CLKS_1, `ADCHPS_ACQ_CLKS_2, `ADCHPS_ACQ_CLKS_3};

  adchps_top u_dut (
    .REF_CLK           (ref_clk),
    .RESET             (rst),
    .CS_N              (cs_n),
    .RD_N              (rd_n),
    .WR_N              (wr_n),
    .WRITE_EDGE_SELECT (wes),
    .PARALLEL_DATA_I   (pins),
    .PARALLEL_DATA_O   (d_o),
    .PARALLEL_DATA_OE  (d_oe),
    .SYNC_I            (sync_i),
    .SYNC_O            (sync_o),
    .SYNC_OE           (sync_oe),
    .READY_N           (ready_n),
    .RAW_SAMPLE        (raw),
    .RAW_OFFSET        (off),
    .SAMPLE_HOLD       (hold),
    .RESULT_VALID      (rv),
    .RESULT_DATA       (rdata),
    .RESULT_READY      (rr)
  );
  adchps_host_model u_host (
    .clk    (ref_clk),
    .cs_n   (cs_n),
    .rd_n   (rd_n),
    .wr_n   (wr_n),
    .dut_o  (d_o),
    .dut_oe (d_oe),
    .pins   (pins)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic results;
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  task automatic chkn(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      bad_count++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chkn
  // bounded wait for ready, a late ready counts as a mismatch
  task automatic wait_low(input int lim);
    int n;
    n = 0;
    while (ready_n !== 1'b0 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk1("ready low in time", 1'b0, ready_n);
  endtask : wait_low

  // edge times, time spent busy, stream beats and the hang ceiling
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    rdy_p <= ready_n;
    syn_p <= sync_o;
    if (ready_n === 1'b1 && rdy_p === 1'b0) t_rise <= cyc;
    if (sync_o === 1'b1 && syn_p === 1'b0) t_sync <= cyc;
    if (ready_n === 1'b1) hi_cnt <= hi_cnt + 1;
    if (rv === 1'b1 && rr === 1'b1) begin
      beats <= beats + 1;
      last_res <= rdata;
    end
    if (cyc == LIMIT) begin
      bad_count++;
      results();
    end
  end

  initial begin
    rst = 1'b1;
    wes = 1'b1;
    sync_i = 1'b0;
    rr = 1'b1;
    raw = 13'h0000;
    off = 13'h0000;
    prev = 13'h0000; // result register starts at zero
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    u_host.pause(4);
    chk1("ready at power-up", 1'b1, ready_n);
    chk("drive at power-up", 13'h0000, d_oe);
    chk1("sync pin at power-up", 1'b0, sync_oe);
    u_host.read(d1, oe);
    chk("power-up width", 13'h00ff, oe);
    // fall value is a reset command, rise value a standby command
    u_host.write(8'h60, 8'h00);
    chk1("ready fall latch", 1'b0, ready_n);
    wes <= ~wes;
    u_host.write(8'h60, 8'h00);
    chk1("ready rise latch", 1'b1, ready_n);
    // narrow asynchronous conversions over every length code
    for (int c = 0; c < 4; c++) begin
      raw <= RAWS[c];
      u_host.write(8'h80 | 8'(c), 8'h80 | 8'(c));
      chk1("ready after start", 1'b0, ready_n);
      u_host.read(d1, oe);
      u_host.read(d2, oe);
      chk("low byte", {5'h00, prev[7:0]}, {5'h00, d1[7:0]});
      chk("high byte", {5'h00, {3{prev[12]}}, prev[12:8]}, {5'h00, d2[7:0]});
      chk("narrow drive", 13'h00ff, oe);
      wait_low(400);
      u_host.pause(3);
      chk1("sync pin output", 1'b1, sync_oe);
      chk("stream result", RAWS[c], last_res);
      acq[c] = t_sync - t_rise;
      prev = RAWS[c];
    end
    for (int c = 1; c < 4; c++) chkn("acquisition", CLKS[c] - CLKS[0], acq[c] - acq[0]);
    // wide reads, single-ended clamp on a negative code
    raw <= 13'h1f00;
    u_host.write(8'h8c, 8'h8c);
    u_host.read(d1, oe);
    chk("wide word", prev, d1);
    chk("wide drive", 13'h1fff, oe);
    wait_low(400);
    u_host.read(d1, oe);
    chk("clamped word", 13'h0000, d1);
    wait_low(400);
    // reset command in mid-acquisition
    raw <= 13'h0abc;
    u_host.write(8'h8b, 8'h8b);
    u_host.read(d1, oe);
    base = t_sync;
    u_host.write(8'h6b, 8'h6b);
    chk1("ready after abort", 1'b0, ready_n);
    u_host.pause(100);
    chkn("no conversion after abort", base, t_sync);
    // synchronous mode waits for the sync pin, length bits ignored
    u_host.write(8'h93, 8'h93);
    chk1("sync pin input", 1'b0, sync_oe);
    base = beats;
    u_host.read(d1, oe);
    u_host.read(d1, oe);
    u_host.pause(120);
    chk1("waiting for sync", 1'b1, ready_n);
    chk1("no hold before sync", 1'b0, hold);
    sync_i <= ~sync_i;
    u_host.pause(4);
    sync_i <= ~sync_i;
    wait_low(400);
    u_host.pause(3);
    chkn("sync conversion", base + 1, beats);
    // fill the result buffer with the sink stalled, then drain it
    rr <= 1'b0;
    u_host.write(8'h88, 8'h88);
    base = beats;
    for (int i = 0; i < 16; i++) begin
      u_host.read(d1, oe);
      if (i < 15) wait_low(400);
    end
    u_host.pause(200);
    chk1("ready with buffer full", 1'b1, ready_n);
    repeat (80) @(posedge ref_clk) rr <= ~rr;
    chkn("buffered results", base + 16, beats);
    chk1("buffer empty", 1'b0, rv);
    chk1("ready after drain", 1'b0, ready_n);
    // auto-zero then full calibration, busy while running
    rr <= 1'b1;
    u_host.write(8'h60, 8'h60);
    off <= off + 13'h0010;
    base = hi_cnt;
    u_host.write(8'h40, 8'h40);
    wait_low(1000);
    az = hi_cnt - base;
    // one conversion with the stored offset applied
    u_host.write(8'h88, 8'h88);
    u_host.read(d1, oe);
    wait_low(400);
    u_host.pause(3);
    chk("offset corrected", 13'h0aac, last_res);
    base = hi_cnt;
    u_host.write(8'h20, 8'h20);
    wait_low(5000);
    fc = hi_cnt - base;
    chk1("auto-zero busy", 1'b1, az >= `ADCHPS_MEAS_CLKS);
    chk1("calibration busy", 1'b1, fc >= 8 * az);
    results();
  end
endmodule : adc_host_port_and_sequencer_tb_top

// ==== dv/adchps_host_model.sv ====
// host side model: strobes, data pin resolution and whole read/write cycles
`timescale 1ns/1ps
module adchps_host_model (
  input  wire logic        clk,
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  input  wire logic [12:0] dut_o,
  input  wire logic [12:0] dut_oe,
  output logic      [12:0] pins
);
  logic [12:0] host_d;  // value the host puts on the pins
  logic        host_oe; // host drives only while writing
  logic [12:0] float_q; // undriven pins wander, never hold a stale value
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    host_oe = 1'b0;
    host_d = 13'h0000;
    float_q = 13'h0aaa;
  end
  // released pins change every cycle so a stale level cannot pass a check
  always @(posedge clk) float_q <= ~float_q;
  // per pin: device first, then host, else the wandering level
  always_comb for (int i = 0; i < 13; i++) pins[i] = dut_oe[i] ? dut_o[i] : (host_oe ? host_d[i] : float_q[i]);
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask : pause
  // one write: val_fall stands over the falling strobe edge, val_rise over the rising one
  task automatic write(input logic [7:0] val_fall, input logic [7:0] val_rise);
    @(posedge clk);
    cs_n <= 1'b0;
    host_oe <= 1'b1;
    host_d <= {5'h00, val_fall};
    pause(1);
    wr_n <= 1'b0;
    pause(8); // strobe must outlast the input filter
    host_d <= {5'h00, val_rise};
    pause(3);
    wr_n <= 1'b1;
    pause(8);
    cs_n <= 1'b1;
    host_oe <= 1'b0;
    pause(6);
  endtask : write
  // one read: pins and enables are taken at the edge that ends the strobe
  task automatic read(output logic [12:0] val, output logic [12:0] oe);
    @(posedge clk);
    cs_n <= 1'b0;
    pause(1);
    rd_n <= 1'b0;
    pause(9); // answer lands four clocks after the fall
    val = pins;
    oe = dut_oe;
    rd_n <= 1'b1;
    pause(8);
    cs_n <= 1'b1;
    pause(6);
  endtask : read
endmodule : adchps_host_model
